// >>> rtl/pdc_device_control.sv
// Summary of operation
// [R1] retry enable: timed-out forwarded config gets retry
// [R2] retry disabled, reset zero: never retry status
// [R3] read request size field, reset 512 bytes
// [R4] read fetch length follows request size field
// [R5] payload size field caps writes, completions
// [R6] no snoop reads zero, never set
// [R7] aux power bit stored, no effect
// [R8] phantom function bit reads zero
// [R9] wide tag bit reads zero
// [R10] relaxed ordering bit reads zero
// [R11] unsupported request reported nonfatal when enabled
// [R12] fatal events reported when enabled
// [R13] nonfatal events reported when enabled
// [R14] correctable events reported when enabled
// [R15] register at 78h, reset 2000h
// [R16] internal counter times forwarded config requests
`timescale 1ns/100ps
`default_nettype none
module pdc_device_control #(
   parameter int TIMEOUT_CYCLES = pdc_pkg::PDC_FWD_TIMEOUT_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [11:0] i_cfg_addr,
   input wire logic i_cfg_wr_en,
   input wire logic [1:0] i_cfg_byte_en,
   input wire logic [15:0] i_cfg_wdata,
   input wire logic i_cfg_rd_en,
   output logic [15:0] o_cfg_rdata,
   output logic o_cfg_rd_valid,
   input wire logic i_fwd_start,
   input wire logic i_fwd_done,
   output logic o_fwd_busy,
   output logic o_retry_cpl,
   output logic [2:0] o_read_request_size_limit,
   output logic [12:0] o_read_req_bytes,
   output logic [2:0] o_payload_size_limit,
   output logic [12:0] o_payload_bytes,
   output logic o_no_snoop_attr,
   input wire logic i_unsupported_req,
   input wire logic i_fatal_event,
   input wire logic i_nonfatal_event,
   input wire logic i_correctable_event,
   output logic o_msg_fatal,
   output logic o_msg_nonfatal,
   output logic o_msg_cor
);
   import pdc_pkg::*;

   logic [15:0] devctl_q;
   logic [15:0] devctl_d;
   logic wr_hit;
   logic rd_hit;
   logic fwd_expire;
   logic retry_en;

   // ***************************************************
   // configuration access
   // ***************************************************
   assign wr_hit = i_cfg_wr_en && (i_cfg_addr == PDC_DEVCTL_OFFSET); // R15
   assign rd_hit = i_cfg_rd_en && (i_cfg_addr == PDC_DEVCTL_OFFSET); // R15

   always_comb
   begin
      devctl_d = devctl_q;
      if (i_cfg_byte_en[0])
      begin
         devctl_d[7:0] = i_cfg_wdata[7:0];
      end
      if (i_cfg_byte_en[1])
      begin
         devctl_d[15:8] = i_cfg_wdata[15:8];
      end
      // fixed-zero bits never take a write
      devctl_d = devctl_d & PDC_DEVCTL_WMASK; // R6 R8 R9 R10
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         devctl_q <= PDC_DEVCTL_RESET; // R15 R2 R3 R5 R7
      end
      else if (wr_hit)
      begin
         devctl_q <= devctl_d; // R3 R5 R7
      end
   end

   // unmapped offsets read zero so the caller always gets an answer
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_cfg_rdata <= 16'h0000;
         o_cfg_rd_valid <= 1'b0;
      end
      else
      begin
         o_cfg_rd_valid <= i_cfg_rd_en;
         if (rd_hit)
         begin
            o_cfg_rdata <= devctl_q;
         end
         else
         begin
            o_cfg_rdata <= 16'h0000;
         end
      end
   end

   // ***************************************************
   // size limits
   // ***************************************************
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_read_request_size_limit <= PDC_DEVCTL_RESET[PDC_RRS_MSB:PDC_RRS_LSB];
         o_read_req_bytes <= pdc_size_bytes(PDC_DEVCTL_RESET[PDC_RRS_MSB:PDC_RRS_LSB]);
         o_payload_size_limit <= PDC_DEVCTL_RESET[PDC_PAY_MSB:PDC_PAY_LSB];
         o_payload_bytes <= pdc_size_bytes(PDC_DEVCTL_RESET[PDC_PAY_MSB:PDC_PAY_LSB]);
      end
      else
      begin
         o_read_request_size_limit <= devctl_q[PDC_RRS_MSB:PDC_RRS_LSB]; // R3
         o_read_req_bytes <= pdc_size_bytes(devctl_q[PDC_RRS_MSB:PDC_RRS_LSB]); // R4
         o_payload_size_limit <= devctl_q[PDC_PAY_MSB:PDC_PAY_LSB]; // R5
         o_payload_bytes <= pdc_size_bytes(devctl_q[PDC_PAY_MSB:PDC_PAY_LSB]); // R5
      end
   end

   assign o_no_snoop_attr = 1'b0; // R6

   // ***************************************************
   // configuration retry
   // ***************************************************
   pdc_fwd_timer #(
      .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
   ) u_fwd_timer (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_start(i_fwd_start),
      .i_done(i_fwd_done),
      .o_busy(o_fwd_busy),
      .o_expire(fwd_expire)
   );

   assign retry_en = devctl_q[PDC_RETRY_BIT];

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_retry_cpl <= 1'b0;
      end
      else
      begin
         o_retry_cpl <= fwd_expire && retry_en; // R1 R2
      end
   end

   // ***************************************************
   // error messages
   // ***************************************************
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_msg_fatal <= 1'b0;
         o_msg_nonfatal <= 1'b0;
         o_msg_cor <= 1'b0;
      end
      else
      begin
         o_msg_fatal <= i_fatal_event && devctl_q[PDC_FATAL_BIT]; // R12
         // unsupported requests share the nonfatal message
         o_msg_nonfatal <= (i_unsupported_req && devctl_q[PDC_UR_BIT]) // R11
            || (i_nonfatal_event && devctl_q[PDC_NONFATAL_BIT]); // R13
         o_msg_cor <= i_correctable_event && devctl_q[PDC_COR_BIT]; // R14
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_full_write;
      wr_hit && i_cfg_byte_en == 2'h3;
   endsequence

   property p_retry_on;
      fwd_expire && retry_en |=> o_retry_cpl;
   endproperty
   a_retry_on: assert property (p_retry_on) else $error("retry missing"); // R1

   property p_retry_off;
      !retry_en |=> !o_retry_cpl;
   endproperty
   a_retry_off: assert property (p_retry_off) else $error("retry while off"); // R2

   property p_rrs_write;
      s_full_write |=> devctl_q[PDC_RRS_MSB:PDC_RRS_LSB]
         == $past(i_cfg_wdata[PDC_RRS_MSB:PDC_RRS_LSB]);
   endproperty
   a_rrs_write: assert property (p_rrs_write) else $error("size write lost"); // R3

   property p_rrs_bytes;
      devctl_q[PDC_RRS_MSB:PDC_RRS_LSB] == 3'h2 ##1
         devctl_q[PDC_RRS_MSB:PDC_RRS_LSB] == 3'h2 |-> o_read_req_bytes == 13'h0200;
   endproperty
   a_rrs_bytes: assert property (p_rrs_bytes) else $error("fetch size wrong"); // R4

   property p_pay_bytes;
      devctl_q[PDC_PAY_MSB:PDC_PAY_LSB] == 3'h5 |=> o_payload_bytes == 13'h1000;
   endproperty
   a_pay_bytes: assert property (p_pay_bytes) else $error("payload size wrong"); // R5

   property p_fixed_zero;
      o_cfg_rd_valid |-> o_cfg_rdata[PDC_NOSNOOP_BIT] == 1'b0 && !o_no_snoop_attr
         && o_cfg_rdata[PDC_PHANTOM_BIT] == 1'b0 && o_cfg_rdata[PDC_WIDETAG_BIT] == 1'b0
         && o_cfg_rdata[PDC_RELAX_BIT] == 1'b0;
   endproperty
   a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bit set"); // R6 R8 R9 R10

   property p_aux_write;
      s_full_write ##1 rd_hit |=> o_cfg_rdata[PDC_AUX_BIT] == $past(i_cfg_wdata[PDC_AUX_BIT], 2);
   endproperty
   a_aux_write: assert property (p_aux_write) else $error("aux bit lost"); // R7

   property p_ur_report;
      i_unsupported_req && devctl_q[PDC_UR_BIT] |=> o_msg_nonfatal;
   endproperty
   a_ur_report: assert property (p_ur_report) else $error("ur not reported"); // R11

   property p_fatal_gate;
      o_msg_fatal |-> $past(devctl_q[PDC_FATAL_BIT]) && $past(i_fatal_event);
   endproperty
   a_fatal_gate: assert property (p_fatal_gate) else $error("fatal gating wrong"); // R12

   property p_nonfatal_report;
      i_nonfatal_event && devctl_q[PDC_NONFATAL_BIT] |=> o_msg_nonfatal;
   endproperty
   a_nonfatal_report: assert property (p_nonfatal_report) else $error("nonfatal lost"); // R13

   property p_cor_gate;
      !devctl_q[PDC_COR_BIT] |=> !o_msg_cor;
   endproperty
   a_cor_gate: assert property (p_cor_gate) else $error("cor while off"); // R14

   property p_readback;
      rd_hit |=> o_cfg_rd_valid && o_cfg_rdata == $past(devctl_q);
   endproperty
   a_readback: assert property (p_readback) else $error("readback wrong"); // R15
endmodule
`default_nettype wire

// >>> rtl/pdc_pkg.sv
package pdc_pkg;
   // ***************************************************
   // register placement
   // ***************************************************
   localparam logic [11:0] PDC_DEVCTL_OFFSET = 12'h078;
   localparam logic [15:0] PDC_DEVCTL_RESET = 16'h2000;
   // bits software may change; the rest read as fixed zero
   localparam logic [15:0] PDC_DEVCTL_WMASK = 16'hF4EF;
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int PDC_RETRY_BIT = 15;
   localparam int PDC_RRS_MSB = 14;
   localparam int PDC_RRS_LSB = 12;
   localparam int PDC_NOSNOOP_BIT = 11;
   localparam int PDC_AUX_BIT = 10;
   localparam int PDC_PHANTOM_BIT = 9;
   localparam int PDC_WIDETAG_BIT = 8;
   localparam int PDC_PAY_MSB = 7;
   localparam int PDC_PAY_LSB = 5;
   localparam int PDC_RELAX_BIT = 4;
   localparam int PDC_UR_BIT = 3;
   localparam int PDC_FATAL_BIT = 2;
   localparam int PDC_NONFATAL_BIT = 1;
   localparam int PDC_COR_BIT = 0;
   // ***************************************************
   // sizes and timing
   // ***************************************************
   localparam int PDC_SIZE_W = 13;
   localparam logic [12:0] PDC_SIZE_BASE = 13'h0080;
   localparam logic [2:0] PDC_SIZE_MAX_CODE = 3'h5;
   localparam int PDC_CLK_PERIOD_NS = 4;
   localparam int PDC_FWD_TIMEOUT_NS = 1000;
   localparam int PDC_FWD_TIMEOUT_CYCLES =
      (PDC_FWD_TIMEOUT_NS + PDC_CLK_PERIOD_NS - 1) / PDC_CLK_PERIOD_NS;

   // reserved codes fall back to the smallest size, the only safe choice
   function automatic logic [12:0] pdc_size_bytes(input logic [2:0] code);
      logic [12:0] bytes;
      bytes = PDC_SIZE_BASE;
      if (code <= PDC_SIZE_MAX_CODE)
      begin
         bytes = PDC_SIZE_BASE << code;
      end
      return bytes;
   endfunction
endpackage

// >>> rtl/pdc_fwd_timer.sv
`timescale 1ns/100ps
`default_nettype none
module pdc_fwd_timer #(
   parameter int TIMEOUT_CYCLES = pdc_pkg::PDC_FWD_TIMEOUT_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_start,
   input wire logic i_done,
   output logic o_busy,
   output logic o_expire
);
   import pdc_pkg::*;
   localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYCLES - 1);

   typedef enum logic [2:0] {
      PDC_IDLE = 3'h1,
      PDC_WAIT = 3'h2,
      PDC_HOLD = 3'h4
   } pdc_tmr_state_type;

   pdc_tmr_state_type state_q;
   logic [CNT_W-1:0] cnt_q;

   // ***************************************************
   // forwarding watch
   // ***************************************************
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         state_q <= PDC_IDLE;
      end
      else
      begin
         case (state_q)
            PDC_IDLE:
            begin
               if (i_start)
               begin
                  state_q <= PDC_WAIT;
               end
            end
            PDC_WAIT:
            begin
               if (i_done)
               begin
                  state_q <= PDC_IDLE;
               end
               else if (cnt_q == LAST)
               begin
                  state_q <= PDC_HOLD;
               end
            end
            // expired; wait for the secondary side to finish before rearming
            PDC_HOLD:
            begin
               if (i_done)
               begin
                  state_q <= PDC_IDLE;
               end
            end
            default:
            begin
               state_q <= PDC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         cnt_q <= '0;
      end
      else if (state_q == PDC_WAIT && !i_done)
      begin
         cnt_q <= cnt_q + CNT_W'(1); // R16
      end
      else
      begin
         cnt_q <= '0;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_expire <= 1'b0;
      end
      else
      begin
         o_expire <= (state_q == PDC_WAIT) && !i_done && (cnt_q == LAST); // R16
      end
   end

   assign o_busy = (state_q != PDC_IDLE);

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   property p_expire_time;
      o_expire |-> $past(cnt_q) == LAST && $past(state_q) == PDC_WAIT;
   endproperty
   a_expire_time: assert property (p_expire_time) else $error("early expire"); // R16
endmodule
`default_nettype wire

// >>> tb/pdc_fwd_peer.sv
`timescale 1ns/100ps
`default_nettype none
module pdc_fwd_peer (
   input wire logic i_ref_clk,
   input wire logic i_start,
   input wire logic [7:0] i_delay,
   output logic o_done
);
   // **************************************
   // secondary bus responder
   // **************************************
   // delay 0 models a bus that never finishes
   logic [7:0] cnt_q;
   initial cnt_q = 8'h00;
   initial o_done = 1'b0;
   always @(posedge i_ref_clk)
   begin
      o_done <= (cnt_q == 8'h01);
      if (i_start)
      begin
         cnt_q <= i_delay;
      end
      else if (cnt_q != 8'h00)
      begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pdc_pkg::*;
   localparam int T = 4;
   logic clk, rst_n, wr, rd, st, tb_done, p_done;
   logic [11:0] addr;
   logic [1:0] be;
   logic [15:0] wd, rdata;
   logic [3:0] ev;
   logic [7:0] dly;
   logic [2:0] rrs, pay;
   logic [12:0] rrb, payb;
   logic rv, busy, rty, ns, mf, mn, mc;
   int err_count, comparisons;
   pdc_device_control #(.TIMEOUT_CYCLES(T)) u_pdc_device_control (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_cfg_addr(addr),
      .i_cfg_wr_en(wr), .i_cfg_byte_en(be), .i_cfg_wdata(wd),
      .i_cfg_rd_en(rd), .o_cfg_rdata(rdata), .o_cfg_rd_valid(rv),
      .i_fwd_start(st), .i_fwd_done(p_done | tb_done),
      .o_fwd_busy(busy), .o_retry_cpl(rty),
      .o_read_request_size_limit(rrs), .o_read_req_bytes(rrb),
      .o_payload_size_limit(pay), .o_payload_bytes(payb),
      .o_no_snoop_attr(ns), .i_unsupported_req(ev[3]),
      .i_fatal_event(ev[2]), .i_nonfatal_event(ev[1]),
      .i_correctable_event(ev[0]), .o_msg_fatal(mf),
      .o_msg_nonfatal(mn), .o_msg_cor(mc));
   pdc_fwd_peer u_pdc_fwd_peer (.i_ref_clk(clk), .i_start(st),
      .i_delay(dly), .o_done(p_done));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // **************************************
   // access tasks
   // **************************************
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      comparisons++;
      if (got !== ex)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, ex, got);
      end
   endtask
   task automatic cwr(input logic [11:0] a, input logic [1:0] b, input logic [15:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      be = b;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic crd(input logic [11:0] a, input logic [15:0] ex);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      chk("rd_valid", 16'h0001, {15'h0, rv});
      chk("rdata", ex, rdata);
   endtask
   // one forwarded request; exp_n is the cycle of retry, 0 for none
   task automatic fwd(input logic r, input logic [7:0] d, input int exp_n);
      int n, got;
      got = 0;
      cwr(12'h078, 2'h2, {r, 15'h2000});
      dly = d;
      @(negedge clk);
      st = 1'b1;
      @(negedge clk);
      st = 1'b0;
      for (n = 1; n <= 20; n++)
      begin
         @(negedge clk);
         if (n == 1) chk("busy", 16'h0001, {15'h0, busy});
         if (rty === 1'b1 && got == 0) got = n;
      end
      chk("retry_at", 16'(exp_n), 16'(got));
      tb_done = 1'b1;
      @(negedge clk);
      tb_done = 1'b0;
      @(negedge clk);
      chk("busy_off", 16'h0000, {15'h0, busy});
   endtask
   task automatic final_report;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // **************************************
   // main sequence
   // **************************************
   initial
   begin
      int c, e, k;
      logic [12:0] xb;
      err_count = 0;
      comparisons = 0;
      {rst_n, wr, rd, st, tb_done} = 5'h00;
      addr = 12'h000;
      be = 2'h0;
      wd = 16'h0000;
      ev = 4'h0;
      dly = 8'h00;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      crd(12'h078, 16'h2000);
      chk("rrs", 16'h0002, {13'h0, rrs});
      chk("rrb", 16'h0200, {3'h0, rrb});
      chk("payb", 16'h0080, {3'h0, payb});
      cwr(12'h078, 2'h3, 16'hFFFF);
      crd(12'h078, 16'hF4EF);
      chk("no_snoop", 16'h0000, {15'h0, ns});
      cwr(12'h078, 2'h1, 16'h0000);
      crd(12'h078, 16'hF400);
      cwr(12'h07A, 2'h3, 16'h0000);
      crd(12'h07A, 16'h0000);
      crd(12'h078, 16'hF400);
      // write then read on the very next edge: the read must see the new value
      @(negedge clk);
      wr = 1'b1;
      addr = 12'h078;
      be = 2'h3;
      wd = 16'h0400;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("rdata_b2b", 16'h0400, rdata);
      for (c = 0; c < 8; c++)
      begin
         cwr(12'h078, 2'h3, {1'b0, c[2:0], 4'h0, c[2:0], 5'h00});
         crd(12'h078, {1'b0, c[2:0], 4'h0, c[2:0], 5'h00});
         chk("rrs", 16'(c), {13'h0, rrs});
         xb = (c <= 5) ? (13'h0080 << c) : 13'h0080;
         chk("rrb", {3'h0, xb}, {3'h0, rrb});
         chk("payb", {3'h0, xb}, {3'h0, payb});
         chk("pay", 16'(c), {13'h0, pay});
      end
      for (e = 0; e < 16; e++)
      begin
         cwr(12'h078, 2'h1, {12'h000, e[3:0]});
         for (k = 0; k < 4; k++)
         begin
            @(negedge clk);
            ev = 4'h1 << k;
            @(negedge clk);
            chk("msgs", {13'h0, ev[2] & e[2], (ev[3] & e[3]) | (ev[1] & e[1]),
               ev[0] & e[0]}, {13'h0, mf, mn, mc});
            ev = 4'h0;
         end
      end
      fwd(1'b1, 8'h00, T + 1);
      fwd(1'b0, 8'h00, 0);
      fwd(1'b1, 8'h02, 0);
      fwd(1'b1, 8'h0A, T + 1);
      // a mid-run reset must bring back the power-up value
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      crd(12'h078, 16'h2000);
      chk("rrs", 16'h0002, {13'h0, rrs});
      chk("pay", 16'h0000, {13'h0, pay});
      chk("busy", 16'h0000, {15'h0, busy});
      final_report;
   end
endmodule
`default_nettype wire
